//--- bench/host_model.sv
// host processor model driving the 4-bit parallel register port
// assumes the bench calls its tasks and wires its pins to the port
`timescale 1ns/1ps
module host_model
   import tone_port_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic [DATA_W-1:0] rd_data_in,
   input  wire logic              rd_oe_in,
   output logic                   sel_out,
   output logic                   wr_n_out,
   output logic                   rd_n_out,
   output logic      [DATA_W-1:0] wr_data_out
);
   // idle bus: strobes high, select low
   initial begin
      sel_out     = 1'b0;
      wr_n_out    = 1'b1;
      rd_n_out    = 1'b1;
      wr_data_out = 4'h0;
   end
   ////////////////////////////////////////////////////////////////////
   // one whole word, strobe held over the take edge, then one idle edge
   task automatic bus_write(input logic s, input logic [DATA_W-1:0] v);
      @(posedge clk_in);
      sel_out     <= s;
      wr_n_out    <= 1'b0;
      wr_data_out <= v;
      repeat (2) @(posedge clk_in);
      wr_n_out    <= 1'b1;
      wr_data_out <= ~v; // released bus must not show the last word
      @(posedge clk_in);
   endtask
   // read: data lands on the take edge, no wait states
   task automatic bus_read(input  logic              s,
                           output logic [DATA_W-1:0] v,
                           output logic              oe);
      @(posedge clk_in);
      sel_out  <= s;
      rd_n_out <= 1'b0;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      v  = rd_data_in;
      oe = rd_oe_in;
      @(posedge clk_in);
      rd_n_out <= 1'b1;
      @(posedge clk_in);
   endtask
   // software reset of both control registers at program start
   task automatic soft_init();
      logic [DATA_W-1:0] v;
      logic              oe;
      bus_read(SEL_CTRL, v, oe);
      bus_write(SEL_CTRL, 4'h0);
      bus_write(SEL_CTRL, 4'h0);
      bus_write(SEL_CTRL, 4'h8);
      bus_write(SEL_CTRL, 4'h0);
      bus_read(SEL_CTRL, v, oe);
   endtask
endmodule

//--- bench/tb_top.sv
// self-checking bench for the tone transceiver host port
// assumes a 40 MHz clock, burst length shortened to BLEN cycles
`timescale 1ns/1ps
module tb_top;
   import tone_port_pkg::*;
   localparam int     BLEN = 5;   // short burst keeps the run brief
   logic              ref_clk_in, rst_in, sel, wr_n, rd_n;
   logic              rx_valid, dsteer, cp_sq, oe, irq_lvl, irq_oe;
   logic              tone_on, single, column;
   logic [DATA_W-1:0] wdata, rx_code, rdata, tone_code;
   int                n_fail = 0, n_compared = 0, on_cnt = 0, cyc = 0;
   wire logic         pin = irq_oe ? irq_lvl : 1'b1; // board pull-up
   ////////////////////////////////////////////////////////////////////
   tone_host_port #(.BURST_CYCLES(BLEN)) dut (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in), .clk_en_in(1'b1),
      .register_select_line_in(sel), .wr_n_in(wr_n), .rd_n_in(rd_n),
      .data_in(wdata), .rx_valid_in(rx_valid), .rx_code_in(rx_code),
      .dsteer_in(dsteer), .cp_square_in(cp_sq), .data_out(rdata),
      .data_oe_out(oe), .interrupt_tone_pin_out(irq_lvl),
      .interrupt_tone_pin_oe_out(irq_oe), .tone_code_out(tone_code),
      .tone_on_out(tone_on), .single_tone_out(single),
      .column_sel_out(column));
   host_model host (
      .clk_in(ref_clk_in), .rd_data_in(rdata), .rd_oe_in(oe),
      .sel_out(sel), .wr_n_out(wr_n), .rd_n_out(rd_n),
      .wr_data_out(wdata));
   ////////////////////////////////////////////////////////////////////
   // clock, tone-cycle counter and hang guard
   initial begin
      ref_clk_in = 1'b0;
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in) begin
      cyc <= cyc + 1;
      if (tone_on === 1'b1) on_cnt <= on_cnt + 1;
      if (cyc == 5000) begin // far above the few hundred cycles needed
         n_fail++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [3:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // read a register and judge both data and bus drive
   task automatic rd(input logic s, input string nm, input logic [3:0] e);
      logic [3:0] v;
      logic       o;
      host.bus_read(s, v, o);
      chk(nm, v, e);
      chk("data_oe_out", o, 1'b1);
   endtask
   task automatic pulse_rx(input logic [3:0] c);
      @(posedge ref_clk_in);
      rx_valid <= 1'b1;
      rx_code  <= c;
      @(posedge ref_clk_in);
      rx_valid <= 1'b0;
      rx_code  <= ~c;
      repeat (3) @(negedge ref_clk_in);
   endtask
   // digit, then a second one that must be dropped mid-burst
   task automatic burst(input logic [3:0] d, input int len, input logic lk);
      int s;
      s = on_cnt;
      host.bus_write(SEL_DIGIT, d);
      host.bus_write(SEL_DIGIT, ~d);
      repeat (4 * len + 10) @(negedge ref_clk_in);
      chk("tone_cycles", 4'(on_cnt - s), 4'(len));
      chk("tone_code_out", tone_code, d);
      if (lk) begin
         chk("pin", pin, 1'b0);
         rd(SEL_CTRL, "status", 4'h3);
      end
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      @(negedge ref_clk_in);
      chk("pin", pin, 1'b1);
      chk("pin_level", irq_lvl, 1'b0);
      chk("tone_on_out", tone_on, 1'b0);
      rd(SEL_CTRL, "status", 4'h0);
      @(negedge ref_clk_in);
      chk("data_oe_out", oe, 1'b0);
      host.soft_init();
   endtask
   task automatic t_rx();
      host.bus_write(SEL_CTRL, 4'h4);
      pulse_rx(4'ha);
      chk("pin", pin, 1'b0);
      rd(SEL_DIGIT, "received", 4'ha);
      rd(SEL_CTRL, "status", 4'h5);
      chk("pin", pin, 1'b1);
      rd(SEL_CTRL, "status", 4'h0);
      @(posedge ref_clk_in);
      dsteer <= 1'b1;
      rd(SEL_CTRL, "status", 4'h8);
      dsteer <= 1'b0;
   endtask
   task automatic t_noirq();
      host.bus_write(SEL_CTRL, 4'h0);
      pulse_rx(4'h3);
      chk("pin", pin, 1'b1);
      rd(SEL_CTRL, "status", 4'h5);
      rd(SEL_DIGIT, "received", 4'h3);
   endtask
   task automatic t_cp();
      host.bus_write(SEL_CTRL, 4'h6);
      @(posedge ref_clk_in);
      cp_sq <= 1'b0;
      repeat (3) @(negedge ref_clk_in);
      chk("pin", pin, 1'b0);
      @(posedge ref_clk_in);
      cp_sq <= 1'b1;
      repeat (3) @(negedge ref_clk_in);
      chk("pin", pin, 1'b1);
      pulse_rx(4'h9);
      rd(SEL_CTRL, "status", 4'h0);
      rd(SEL_DIGIT, "received", 4'h3);
   endtask
   task automatic t_burst();
      host.bus_write(SEL_CTRL, 4'h9);
      host.bus_write(SEL_CTRL, 4'hc);
      @(negedge ref_clk_in);
      chk("single_tone_out", single, 1'b1);
      chk("column_sel_out", column, 1'b1);
      host.bus_write(SEL_CTRL, 4'h5);
      @(negedge ref_clk_in);
      chk("single_tone_out", single, 1'b1);
      burst(4'h7, BLEN, 1'b1);
      host.bus_write(SEL_CTRL, 4'h7);
      burst(4'h2, 2 * BLEN, 1'b0);
   endtask
   task automatic t_burstoff();
      // test mode: pin follows the delayed steering bit
      host.bus_write(SEL_CTRL, 4'hc);
      host.bus_write(SEL_CTRL, 4'h2);
      repeat (3) @(negedge ref_clk_in);
      chk("pin", pin, 1'b0);
      @(posedge ref_clk_in);
      dsteer <= 1'b1;
      repeat (3) @(negedge ref_clk_in);
      chk("pin", pin, 1'b1);
      @(posedge ref_clk_in);
      dsteer <= 1'b0;
      host.bus_write(SEL_CTRL, 4'h9);
      host.bus_write(SEL_CTRL, 4'h1);
      @(negedge ref_clk_in);
      chk("single_tone_out", single, 1'b0);
      rd(SEL_CTRL, "status", 4'h0);
      host.bus_write(SEL_DIGIT, 4'he);
      @(negedge ref_clk_in);
      chk("tone_code_out", tone_code, 4'he);
      chk("tone_on_out", tone_on, 1'b1);
      host.bus_write(SEL_CTRL, 4'h0);
      @(negedge ref_clk_in);
      chk("tone_on_out", tone_on, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rst_in   = 1'b1;
      rx_valid = 1'b0;
      rx_code  = 4'h0;
      dsteer   = 1'b0;
      cp_sq    = 1'b1;
      repeat (12) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      t_reset();
      t_rx();
      t_noirq();
      t_cp();
      t_burst();
      t_burstoff();
      wrap_up();
   end
endmodule

//--- hdl/tone_host_port.sv
// register port, control and interrupt pin of the tone transceiver
// assumes host strobes and receiver inputs synchronous to ref_clk_in
`timescale 1ns/1ps
module tone_host_port
   import tone_port_pkg::*;
#(
   parameter int BURST_CYCLES = BURST_CYC  // burst and pause length
)(
   input  wire logic              ref_clk_in,
   input  wire logic              rst_in,
   input  wire logic              clk_en_in,
   input  wire logic              register_select_line_in,
   input  wire logic              wr_n_in,
   input  wire logic              rd_n_in,
   input  wire logic [DATA_W-1:0] data_in,
   input  wire logic              rx_valid_in,
   input  wire logic [DATA_W-1:0] rx_code_in,
   input  wire logic              dsteer_in,
   input  wire logic              cp_square_in,
   output logic      [DATA_W-1:0] data_out,
   output logic                   data_oe_out,
   output logic                   interrupt_tone_pin_out,
   output logic                   interrupt_tone_pin_oe_out,
   output logic      [DATA_W-1:0] tone_code_out,
   output logic                   tone_on_out,
   output logic                   single_tone_out,
   output logic                   column_sel_out
);
   // refuse counts that the counter cannot hold
   if (BURST_CYCLES < 1 || 2 * BURST_CYCLES >= 2 ** CNT_W) begin : g_chk
      $error("BURST_CYCLES out of range");
   end

   localparam logic [CNT_W-1:0] ONE_CYC = CNT_W'(1);

   ////////////////////////////////////////////////////////////////////
   // host register group
   logic              wr_n_ff, nxt_wr_n;       // strobe history
   logic              rd_n_ff, nxt_rd_n;
   first_ctrl_t       ctrl1_ff, nxt_ctrl1;     // first control
   second_ctrl_t      ctrl2_ff, nxt_ctrl2;     // second control
   logic              bank_ff, nxt_bank;       // next write to second
   logic [DATA_W-1:0] txd_ff, nxt_txd;         // transmit digit
   logic [DATA_W-1:0] rxd_ff, nxt_rxd;         // received digit
   logic              txe_ff, nxt_txe;         // transmitter ready
   logic              rxf_ff, nxt_rxf;         // digit waiting
   logic              dst_ff, nxt_dst;         // delayed steering
   logic [DATA_W-1:0] dout_ff, nxt_dout;       // read data
   logic              doe_ff, nxt_doe;
   logic              wr_take, rd_take;        // strobe leading edges
   logic              tx_write, st_read;
   logic              pause_done;              // from the sequencer
   burst_state_t      bst_ff, nxt_bst;
   logic [CNT_W-1:0]  cnt_ff, nxt_cnt;
   logic [DATA_W-1:0] status;

   // an access is taken once, on the strobe's falling edge
   assign wr_take  = clk_en_in & wr_n_ff & ~wr_n_in;
   assign rd_take  = clk_en_in & rd_n_ff & ~rd_n_in;
   assign tx_write = wr_take & (register_select_line_in == SEL_DIGIT);
   assign st_read  = rd_take & (register_select_line_in == SEL_CTRL);

   // status word, bit 0 is the or of both events
   always_comb begin
      status            = '0;
      status[ST_TXE]    = txe_ff;
      status[ST_RXF]    = rxf_ff;
      status[ST_IRQ]    = txe_ff | rxf_ff;
      status[ST_DSTEER] = dst_ff;
   end

   // decode of writes, reads and event flags
   always_comb begin
      nxt_wr_n  = wr_n_ff;
      nxt_rd_n  = rd_n_ff;
      nxt_ctrl1 = ctrl1_ff;
      nxt_ctrl2 = ctrl2_ff;
      nxt_bank  = bank_ff;
      nxt_txd   = txd_ff;
      nxt_rxd   = rxd_ff;
      nxt_txe   = txe_ff;
      nxt_rxf   = rxf_ff;
      nxt_dst   = dst_ff;
      nxt_dout  = dout_ff;
      nxt_doe   = doe_ff;
      if (clk_en_in) begin
         nxt_wr_n = wr_n_in;
         nxt_rd_n = rd_n_in;
         nxt_doe  = ~rd_n_in;          // drive only while reading
         nxt_dst  = dsteer_in;
         if (wr_take) begin
            if (register_select_line_in == SEL_DIGIT) begin
               // writes while a burst runs are dropped
               if (bst_ff == B_IDLE)
                  nxt_txd = data_in;
            end else if (bank_ff) begin
               nxt_ctrl2 = second_ctrl_t'(data_in);
               nxt_bank  = 1'b0;
            end else begin
               nxt_ctrl1 = first_ctrl_t'(data_in);
               nxt_bank  = data_in[BANK_BIT];
            end
         end
         if (rd_take) begin
            // the reply carries the state before any clear
            if (register_select_line_in == SEL_DIGIT)
               nxt_dout = rxd_ff;
            else
               nxt_dout = status;
         end
         // a status read clears, a same-cycle event wins
         if (st_read) begin
            nxt_txe = 1'b0;
            nxt_rxf = 1'b0;
         end
         if (ctrl2_ff.burst_off)
            nxt_txe = 1'b0;
         else if (pause_done)
            nxt_txe = 1'b1;
         // digits are not detected in call-progress mode
         if (rx_valid_in && !ctrl1_ff.call_progress_select) begin
            nxt_rxd = rx_code_in;
            nxt_rxf = 1'b1;
         end
      end
   end

   // register group flops
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         wr_n_ff  <= 1'b1;
         rd_n_ff  <= 1'b1;
         ctrl1_ff <= first_ctrl_t'(CTRL_RST);
         ctrl2_ff <= second_ctrl_t'(CTRL_RST);
         bank_ff  <= 1'b0;
         txd_ff   <= DIGIT_RST;
         rxd_ff   <= DIGIT_RST;
         txe_ff   <= 1'b0;
         rxf_ff   <= 1'b0;
         dst_ff   <= 1'b0;
         dout_ff  <= '0;
         doe_ff   <= 1'b0;
      end else begin
         wr_n_ff  <= nxt_wr_n;
         rd_n_ff  <= nxt_rd_n;
         ctrl1_ff <= nxt_ctrl1;
         ctrl2_ff <= nxt_ctrl2;
         bank_ff  <= nxt_bank;
         txd_ff   <= nxt_txd;
         rxd_ff   <= nxt_rxd;
         txe_ff   <= nxt_txe;
         rxf_ff   <= nxt_rxf;
         dst_ff   <= nxt_dst;
         dout_ff  <= nxt_dout;
         doe_ff   <= nxt_doe;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // burst sequencer: tone, equal pause, then transmitter ready
   logic [CNT_W-1:0] burst_len;

   // call-progress mode doubles both halves
   assign burst_len = ctrl1_ff.call_progress_select
                    ? CNT_W'(2 * BURST_CYCLES)
                    : CNT_W'(BURST_CYCLES);
   assign pause_done = clk_en_in & (bst_ff == B_PAUSE)
                     & (cnt_ff == ONE_CYC);

   // next state of the sequencer
   always_comb begin
      nxt_bst = bst_ff;
      nxt_cnt = cnt_ff;
      if (clk_en_in) begin
         unique case (bst_ff)
            B_IDLE: begin
               if (tx_write && !ctrl2_ff.burst_off) begin
                  nxt_bst = B_TONE;
                  nxt_cnt = burst_len;
               end
            end
            B_TONE: begin
               if (cnt_ff == ONE_CYC) begin
                  nxt_bst = B_PAUSE;
                  nxt_cnt = burst_len;
               end else
                  nxt_cnt = cnt_ff - ONE_CYC;
            end
            B_PAUSE: begin
               if (cnt_ff == ONE_CYC)
                  nxt_bst = B_IDLE;
               else
                  nxt_cnt = cnt_ff - ONE_CYC;
            end
            default: begin
               nxt_bst = B_IDLE;
               nxt_cnt = '0;
            end
         endcase
         // leaving burst mode abandons a burst in flight
         if (ctrl2_ff.burst_off)
            nxt_bst = B_IDLE;
      end
   end

   // sequencer flops
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         bst_ff <= B_IDLE;
         cnt_ff <= '0;
      end else begin
         bst_ff <= nxt_bst;
         cnt_ff <= nxt_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // output group: tone generator control and shared pin
   logic              pin_low_ff, nxt_pin_low;
   logic [DATA_W-1:0] code_ff, nxt_code;
   logic              ton_ff, nxt_ton;
   logic              sgl_ff, nxt_sgl;
   logic              col_ff, nxt_col;

   // pin and tone control, registered for clean outputs
   always_comb begin
      nxt_pin_low = pin_low_ff;
      nxt_code    = code_ff;
      nxt_ton     = ton_ff;
      nxt_sgl     = sgl_ff;
      nxt_col     = col_ff;
      if (clk_en_in) begin
         nxt_code = txd_ff;
         // tone bit gates only tone_on_out; code, single tone and column pass ungated
         nxt_ton  = ctrl1_ff.tone_output_enable
                  & (ctrl2_ff.burst_off
                     | (bst_ff == B_TONE));
         // frequencies themselves come from the synthesiser
         nxt_sgl  = ctrl2_ff.single_tone;
         nxt_col  = ctrl2_ff.column_sel;
         if (!ctrl1_ff.irq_enable)
            nxt_pin_low = 1'b0;
         else if (ctrl1_ff.call_progress_select)
            nxt_pin_low = ~cp_square_in;
         else if (ctrl2_ff.test_mode)
            nxt_pin_low = ~dst_ff;
         else
            nxt_pin_low = status[ST_IRQ];
      end
   end

   // output flops
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         pin_low_ff <= 1'b0;
         code_ff    <= DIGIT_RST;
         ton_ff     <= 1'b0;
         sgl_ff     <= 1'b0;
         col_ff     <= 1'b0;
      end else begin
         pin_low_ff <= nxt_pin_low;
         code_ff    <= nxt_code;
         ton_ff     <= nxt_ton;
         sgl_ff     <= nxt_sgl;
         col_ff     <= nxt_col;
      end
   end

   // open drain: level held low, only the enable moves
   assign interrupt_tone_pin_out    = 1'b0;
   assign interrupt_tone_pin_oe_out = pin_low_ff;
   assign data_out                  = dout_ff;
   assign data_oe_out               = doe_ff;
   assign tone_code_out             = code_ff;
   assign tone_on_out               = ton_ff;
   assign single_tone_out           = sgl_ff;
   assign column_sel_out            = col_ff;

   ////////////////////////////////////////////////////////////////////
   // checks
   sequence s_bank_arm;
      clk_en_in && wr_take && register_select_line_in && !bank_ff
      && data_in[BANK_BIT];
   endsequence
   // a control write while the pointer is armed lands in the second
   sequence s_second_write;
      clk_en_in && wr_take && register_select_line_in && bank_ff;
   endsequence

   a_bank_arm: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      s_bank_arm |=> bank_ff)
      else $error("bank pointer not armed");
   a_bank_route: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      s_second_write |=> !bank_ff && ctrl2_ff == $past(data_in))
      else $error("second control write misrouted");
   a_rx_read: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      rd_take && !register_select_line_in |=> dout_ff == $past(rxd_ff))
      else $error("received digit read wrong");
   a_st_read: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      st_read |=> dout_ff == $past(status))
      else $error("status read wrong");
   a_cp_no_rx: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      ctrl1_ff.call_progress_select |=> rxd_ff == $past(rxd_ff))
      else $error("digit taken in call-progress mode");
   a_rx_flag: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      clk_en_in && rx_valid_in && !ctrl1_ff.call_progress_select
      |=> rxf_ff && rxd_ff == $past(rx_code_in))
      else $error("receive-full not set");
   a_irq_off: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !ctrl1_ff.irq_enable ##1 !ctrl1_ff.irq_enable |-> !pin_low_ff)
      else $error("pin pulled with interrupts off");
   a_irq_pull: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      clk_en_in && ctrl1_ff.irq_enable && !ctrl1_ff.call_progress_select
      && !ctrl2_ff.test_mode && (txe_ff || rxf_ff) |=> pin_low_ff)
      else $error("interrupt not signalled");
   a_tone_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !ctrl1_ff.tone_output_enable ##1 !ctrl1_ff.tone_output_enable
      |-> !ton_ff)
      else $error("tone on while disabled");
   a_txe_burst: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      pause_done && !ctrl2_ff.burst_off |=> txe_ff && bst_ff == B_IDLE)
      else $error("transmitter ready not set");
endmodule

//--- hdl/tone_port_pkg.sv
// constants and carriers for the tone transceiver host port
// assumes a 40 MHz clock and a 4-bit host data bus
package tone_port_pkg;
   localparam int          DATA_W      = 4;     // host bus width
   localparam logic        SEL_DIGIT   = 1'b0;  // digit registers
   localparam logic        SEL_CTRL    = 1'b1;  // control / status
   localparam logic [3:0]  CTRL_RST    = 4'h0;  // both control regs
   localparam logic [3:0]  DIGIT_RST   = 4'h0;  // digit registers
   // first control register fields
   localparam int          TONE_OUTPUT_ENABLE_BIT    = 0;
   localparam int          CP_BIT      = 1;
   localparam int          IRQ_BIT     = 2;
   localparam int          BANK_BIT    = 3;
   // second control register fields
   localparam int          BURST_BIT   = 0;     // low enables burst
   localparam int          TEST_BIT    = 1;
   localparam int          SINGLE_BIT  = 2;
   localparam int          COLUMN_BIT  = 3;
   // status fields
   localparam int          ST_IRQ      = 0;
   localparam int          ST_TXE      = 1;
   localparam int          ST_RXF      = 2;
   localparam int          ST_DSTEER   = 3;
   // burst and pause timing
   localparam int          CLK_NS      = 25;       // clock period
   localparam int          BURST_NS    = 51000000; // 51 ms
   localparam int          BURST_CYC   = BURST_NS / CLK_NS;
   localparam int          CNT_W       = 24;
   // first control register as a carrier
   typedef struct packed {
      logic bank_select_bit;
      logic irq_enable;
      logic call_progress_select;
      logic tone_output_enable;
   } first_ctrl_t;
   // second control register as a carrier
   typedef struct packed {
      logic column_sel;
      logic single_tone;
      logic test_mode;
      logic burst_off;
   } second_ctrl_t;
   // burst sequencer states, one-hot
   typedef enum logic [2:0] {
      B_IDLE  = 3'b001,
      B_TONE  = 3'b010,
      B_PAUSE = 3'b100
   } burst_state_t;
endpackage
